/* File: trig_frame_link.sv */
// Sensor-side triggered nibble frame transmitter with AXI4-Lite configuration.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module trig_frame_link
  import trig_frame_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Measurement and diagnostics from the sensor core
  input wire logic [11:0] angle_in,
  input wire logic [7:0] temp_in,
  input wire logic warn_in,
  input wire logic err_in,
  // Open-drain line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_n
);

  function automatic logic [3:0] crc_mul16(input logic [3:0] c);
    logic [3:0] v;
    v = c;
    for (int i = 0; i < 4; i++)
    begin
      v = v[3] ? ({v[2:0], 1'b0} ^ CRC_POLY) : {v[2:0], 1'b0};
    end
    return v;
  endfunction

  function automatic logic [3:0] crc_step(input logic [3:0] c, input logic [3:0] n);
    return n ^ crc_mul16(c);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        v[8*i +: 8] = d[8*i +: 8];
    end
    return v;
  endfunction

  logic [31:0] ctrl_r;
  logic [15:0] base_r, sid1_r, sid2_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r;
  link_state_t st_r;
  logic line_s1_r, line_s2_r, line_prev_r;
  logic [8:0] div_r;
  logic [7:0] low_cnt_r;
  logic [8:0] total_cnt_r;
  logic [2:0] seg_r;
  logic [6:0] tx_cnt_r;
  logic [3:0] nib_r [6];
  logic [2:0] n_nib_r;
  logic [3:0] roll_r;
  logic [3:0] ssm_pos_r, ssm_id_r;
  logic [15:0] block_r;

  logic [1:0] cfg_addr;
  logic cfg_const, cfg_low5, cfg_ssm, cfg_fold, cfg_nib;
  logic [1:0] cfg_ut;
  assign cfg_addr = ctrl_r[CTRL_ADDR_LSB +: 2];
  assign cfg_const = ctrl_r[CTRL_CONST_BIT];
  assign cfg_low5 = ctrl_r[CTRL_LOW5_BIT];
  assign cfg_ssm = ctrl_r[CTRL_SSM_BIT];
  assign cfg_ut = ctrl_r[CTRL_UT_LSB +: 2];
  assign cfg_fold = ctrl_r[CTRL_CNT_LSB +: 2] == CNT_FOLD;
  assign cfg_nib = !cfg_fold && ctrl_r[CTRL_CNT_LSB +: 2] != CNT_OFF;

  // AXI4-Lite slave: address and data are taken in either order.
  logic aw_take, w_take, do_write, ar_take;
  assign aw_take = awvalid && awready;
  assign w_take = wvalid && wready;
  assign do_write = aw_have_r && w_have_r && !bvalid;
  assign ar_take = arvalid && arready;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_addr_r <= awaddr;
        aw_have_r <= 1'b1;
        awready <= 1'b0;
      end
      if (w_take)
      begin
        w_data_r <= wdata;
        w_strb_r <= wstrb;
        w_have_r <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr_r == CTRL_OFS || aw_addr_r == BASE_OFS || aw_addr_r == ID1_OFS ||
                  aw_addr_r == ID2_OFS || aw_addr_r == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Configuration changes take effect at once; software should write it between frames.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_RESET;
      base_r <= WORD_RESET;
      sid1_r <= WORD_RESET;
      sid2_r <= WORD_RESET;
    end
    else if (do_write)
    begin
      case (aw_addr_r)
        CTRL_OFS: ctrl_r <= lane_merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_01FF;
        BASE_OFS: base_r <= 16'(lane_merge({16'h0000, base_r}, w_data_r, w_strb_r));
        ID1_OFS: sid1_r <= 16'(lane_merge({16'h0000, sid1_r}, w_data_r, w_strb_r));
        ID2_OFS: sid2_r <= 16'(lane_merge({16'h0000, sid2_r}, w_data_r, w_strb_r));
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end
    else if (ar_take)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (araddr)
        CTRL_OFS: rdata <= ctrl_r;
        BASE_OFS: rdata <= {16'h0000, base_r};
        ID1_OFS: rdata <= {16'h0000, sid1_r};
        ID2_OFS: rdata <= {16'h0000, sid2_r};
        STAT_OFS: rdata <= {16'h0000, low_cnt_r, 3'b000, st_r != ST_IDLE, roll_r};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Line synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_s1_r <= 1'b1;
      line_s2_r <= 1'b1;
      line_prev_r <= 1'b1;
    end
    else
    begin
      line_s1_r <= line_in;
      line_s2_r <= line_s1_r;
      line_prev_r <= line_s2_r;
    end
  end

  logic fall, rise;
  assign fall = line_prev_r && !line_s2_r;
  assign rise = !line_prev_r && line_s2_r;

  logic [8:0] half_cyc;
  logic half;
  assign half_cyc = 9'(((UT_BASE_STEPS + int'(cfg_ut)) * UT_STEP_NS) / (2 * CLK_PERIOD_NS));
  assign half = div_r == half_cyc - 9'h001;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      div_r <= '0;
    else if ((st_r == ST_IDLE && fall) || half)
      div_r <= '0;
    else
      div_r <= div_r + 9'h001;
  end

  logic hit;
  logic [8:0] target;
  logic start_frame, last_seg, seg_end;
  logic [6:0] seg_len, low_h;
  assign hit = low_cnt_r >= TRIG_MIN_HALF[cfg_addr] && low_cnt_r <= TRIG_MAX_HALF[cfg_addr];
  assign target = cfg_const ? TRIG_CONST_HALF : {1'b0, low_cnt_r} + TRIG_VAR_ADD_HALF;
  assign start_frame = st_r == ST_TRIG_WAIT && half && total_cnt_r >= target - 9'h001;
  assign last_seg = seg_r == n_nib_r + 3'h1;
  assign seg_len = (seg_r == 3'h0) ? SYNC_HALF : last_seg ? END_HALF :
                   7'((NIB_BASE_UT + 7'(nib_r[seg_r - 3'h1])) << 1);
  assign seg_end = half && tx_cnt_r == seg_len - 7'h01;
  assign low_h = cfg_low5 ? LOW5_HALF : LOW3_HALF;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= ST_WAIT_HIGH;
    else
    begin
      case (st_r)
        ST_WAIT_HIGH: if (line_s2_r) st_r <= ST_IDLE;
        ST_IDLE: if (fall) st_r <= ST_TRIG_LOW;
        ST_TRIG_LOW: if (rise) st_r <= hit ? ST_TRIG_WAIT : ST_IDLE;
        ST_TRIG_WAIT: if (start_frame) st_r <= ST_TX;
        ST_TX: if (seg_end && last_seg) st_r <= ST_WAIT_HIGH;
        default: st_r <= ST_WAIT_HIGH;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      low_cnt_r <= '0;
      total_cnt_r <= '0;
    end
    else if (st_r == ST_IDLE)
    begin
      if (fall)
      begin
        low_cnt_r <= '0;
        total_cnt_r <= '0;
      end
    end
    else if (half && (st_r == ST_TRIG_LOW || st_r == ST_TRIG_WAIT))
    begin
      if (st_r == ST_TRIG_LOW && low_cnt_r != 8'hFF)
        low_cnt_r <= low_cnt_r + 8'h01;
      if (total_cnt_r != 9'h1FF)
        total_cnt_r <= total_cnt_r + 9'h001;
    end
  end

  // Slow channel block for the current identifier.
  logic [7:0] ssm_data;
  logic [15:0] block_now;
  logic ssm_bit;
  always_comb
  begin
    case (ssm_id_r[2:0])
      3'h1: ssm_data = base_r[15:8];
      3'h2: ssm_data = base_r[7:0];
      3'h4: ssm_data = sid1_r[15:8];
      3'h5: ssm_data = sid1_r[7:0];
      3'h6: ssm_data = sid2_r[15:8];
      3'h7: ssm_data = sid2_r[7:0];
      default: ssm_data = temp_in;
    endcase
    block_now = {ssm_id_r, ssm_data, crc_mul16(crc_step(crc_step(crc_step(CRC_SEED, ssm_id_r),
                 ssm_data[7:4]), ssm_data[3:0]))};
    ssm_bit = (ssm_pos_r == 4'h0) ? block_now[15] : block_r[4'hF - ssm_pos_r];
  end

  // Frame nibbles and checksum assembled at frame start.
  logic [3:0] stat_nib, crc_nib, crc_acc;
  always_comb
  begin
    stat_nib = {err_in, warn_in, cfg_ssm ? {ssm_pos_r == 4'h0, ssm_bit} : cfg_addr};
    crc_acc = crc_step(CRC_SEED, stat_nib);
    crc_acc = crc_step(crc_acc, angle_in[11:8]);
    crc_acc = crc_step(crc_acc, angle_in[7:4]);
    crc_acc = crc_step(crc_acc, angle_in[3:0]);
    if (cfg_nib)
      crc_acc = crc_step(crc_acc, roll_r);
    if (cfg_fold || cfg_ssm)
      crc_acc = crc_step(crc_acc, {cfg_fold ? roll_r[1:0] : 2'b00, cfg_ssm ? cfg_addr : 2'b00});
    crc_nib = crc_mul16(crc_acc);
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 6; i++)
        nib_r[i] <= 4'h0;
      n_nib_r <= 3'h5;
    end
    else if (start_frame)
    begin
      nib_r[0] <= stat_nib;
      nib_r[1] <= angle_in[11:8];
      nib_r[2] <= angle_in[7:4];
      nib_r[3] <= angle_in[3:0];
      nib_r[4] <= cfg_nib ? roll_r : crc_nib;
      nib_r[5] <= crc_nib;
      n_nib_r <= cfg_nib ? 3'h6 : 3'h5;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      roll_r <= 4'h0;
    else if (start_frame)
      roll_r <= roll_r + 4'h1;
  end

  // one bit per frame, sixteen per block
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ssm_pos_r <= 4'h0;
      ssm_id_r <= 4'h0;
      block_r <= 16'h0000;
    end
    else if (start_frame && cfg_ssm)
    begin
      ssm_pos_r <= ssm_pos_r + 4'h1;
      if (ssm_pos_r == 4'h0)
        block_r <= block_now;
      if (ssm_pos_r == 4'hF)
        ssm_id_r <= ssm_id_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      seg_r <= 3'h0;
      tx_cnt_r <= 7'h00;
    end
    else if (start_frame)
    begin
      seg_r <= 3'h0;
      tx_cnt_r <= 7'h00;
    end
    else if (st_r == ST_TX && half)
    begin
      tx_cnt_r <= seg_end ? 7'h00 : tx_cnt_r + 7'h01;
      if (seg_end)
        seg_r <= seg_r + 3'h1;
    end
  end

  // drive low only in the low phase
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_oe_n <= 1'b1;
      line_out <= 1'b0;
    end
    else
    begin
      line_oe_n <= !(st_r == ST_TX && tx_cnt_r < low_h);
      line_out <= 1'b0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence trig_accepted;
    st_r == ST_TRIG_LOW && rise && hit;
  endsequence
  sequence frame_go;
    start_frame;
  endsequence

  tx_after_trig_a: assert property ($rose(st_r == ST_TX) |-> $past(st_r) == ST_TRIG_WAIT)
    else $error("frame started without trigger");
  addr_window_a: assert property (trig_accepted |=> st_r == ST_TRIG_WAIT)
    else $error("valid own trigger not accepted");
  foreign_trig_a: assert property (st_r == ST_TRIG_LOW && rise && !hit |=> st_r == ST_IDLE)
    else $error("foreign trigger not ignored");
  const_len_a: assert property (frame_go and cfg_const |-> total_cnt_r == TRIG_CONST_HALF - 9'h001)
    else $error("constant trigger length wrong");
  var_len_a: assert property (frame_go and !cfg_const |-> total_cnt_r == {1'b0, low_cnt_r} + 9'h017)
    else $error("variable trigger length wrong");
  low_phase_a: assert property (!line_oe_n |-> $past(st_r == ST_TX && tx_cnt_r < low_h))
    else $error("line driven outside low phase");
  roll_inc_a: assert property (frame_go ##1 1'b1 |-> roll_r == $past(roll_r) + 4'h1)
    else $error("rolling counter did not step");
  addr_status_a: assert property (frame_go and !cfg_ssm |=> nib_r[0][1:0] == $past(cfg_addr))
    else $error("address missing from status");
  ssm_start_a: assert property (frame_go and cfg_ssm |=> nib_r[0][1] == ($past(ssm_pos_r) == 4'h0))
    else $error("slow channel start bit wrong");
  idle_release_a: assert property (st_r != ST_TX ##1 st_r != ST_TX |-> line_oe_n)
    else $error("line driven outside a frame");

endmodule // trig_frame_link
`default_nettype wire

/* File: trig_frame_pkg.sv */
// Shared constants and types for the triggered sensor frame link.
`default_nettype none
package trig_frame_pkg;
  // Clock and unit-time step (unit time = (3 + select) * 0.5 us).
  localparam int CLK_PERIOD_NS = 10;
  localparam int UT_STEP_NS = 500;
  localparam int UT_BASE_STEPS = 3;
  // Link timing is counted in half unit times, except NIB_BASE_UT, which is in unit times.
  localparam logic [7:0] TRIG_MIN_HALF [4] = '{8'h12, 8'h26, 8'h47, 8'h7B};
  localparam logic [7:0] TRIG_MAX_HALF [4] = '{8'h18, 8'h2E, 8'h51, 8'h87};
  localparam logic [8:0] TRIG_CONST_HALF = 9'h0B4;
  localparam logic [8:0] TRIG_VAR_ADD_HALF = 9'h018;
  localparam logic [6:0] SYNC_HALF = 7'h70;
  localparam logic [6:0] END_HALF = 7'h18;
  localparam logic [6:0] NIB_BASE_UT = 7'h0C;
  localparam logic [6:0] LOW3_HALF = 7'h06;
  localparam logic [6:0] LOW5_HALF = 7'h0A;
  // Frame checksum.
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [3:0] CRC_POLY = 4'hD;
  // Register byte offsets.
  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] BASE_OFS = 5'h04;
  localparam logic [4:0] ID1_OFS = 5'h08;
  localparam logic [4:0] ID2_OFS = 5'h0C;
  localparam logic [4:0] STAT_OFS = 5'h10;
  // Control register fields and reset value.
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_CONST_BIT = 2;
  localparam int CTRL_LOW5_BIT = 3;
  localparam int CTRL_CNT_LSB = 4;
  localparam int CTRL_SSM_BIT = 6;
  localparam int CTRL_UT_LSB = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Status register fields.
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_LOW_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    CNT_NIBBLE = 2'b00,
    CNT_OFF = 2'b01,
    CNT_FOLD = 2'b10
  } cnt_mode_t;

  typedef enum logic [2:0] {
    ST_WAIT_HIGH = 3'b000,
    ST_IDLE = 3'b001,
    ST_TRIG_LOW = 3'b010,
    ST_TRIG_WAIT = 3'b011,
    ST_TX = 3'b100
  } link_state_t;
endpackage
`default_nettype wire

/* File: trig_master_model.sv */
// Master model that triggers the sensor and times the frame edges on the shared line.
`default_nettype none
module trig_master_model
#(
  parameter int HALF = 75
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Trigger request
  input wire logic trig_go,
  input wire logic [7:0] trig_halves,
  // Shared line
  input wire logic line_lvl,
  output logic rel,
  // Measured segment: low time and fall-to-fall spacing in half units
  output logic seg_valid,
  output logic [15:0] seg
);
  timeunit 1ns;
  timeprecision 1ns;
  int tcnt;
  int cyc;
  int t_fall;
  logic [7:0] low_h;
  logic lvl_q;
  logic armed;

  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rel <= 1'b1;
      tcnt <= 0;
    end
    else if (trig_go)
    begin
      rel <= 1'b0;
      tcnt <= trig_halves * HALF - 1;
    end
    else if (tcnt > 0)
      tcnt <= tcnt - 1;
    else
      rel <= 1'b1;
  end

  // The first fall after a trigger request is the master's own and only arms the timer.
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc <= 0;
      t_fall <= 0;
      low_h <= 8'h00;
      lvl_q <= 1'b1;
      armed <= 1'b0;
      seg_valid <= 1'b0;
      seg <= 16'h0000;
    end
    else
    begin
      cyc <= cyc + 1;
      lvl_q <= line_lvl;
      seg_valid <= 1'b0;
      if (trig_go)
        armed <= 1'b0;
      else if (lvl_q && !line_lvl)
      begin
        t_fall <= cyc;
        armed <= 1'b1;
        seg_valid <= armed;
        seg <= {low_h, 8'((cyc - t_fall + HALF / 2) / HALF)};
      end
      else if (!lvl_q && line_lvl)
        low_h <= 8'((cyc - t_fall + HALF / 2) / HALF);
    end
  end
endmodule // trig_master_model
`default_nettype wire

/* File: trig_frame_link_tb.sv */
// Self-checking bench for the triggered sensor frame link.
`default_nettype none
module trig_frame_link_tb
  import trig_frame_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = UT_STEP_NS * UT_BASE_STEPS / (2 * CLK_PERIOD_NS);
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] awaddr = 5'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [4:0] araddr = 5'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] angle_in = 12'h000;
  logic [7:0] temp_in = 8'h00;
  logic warn_in = 1'b0;
  logic err_in = 1'b0;
  logic trig_go = 1'b0;
  logic [7:0] trig_halves = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, line_out, line_oe_n, rel, seg_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] seg;
  wire logic line_lvl;
  logic [33:0] exp_rsp [$];
  logic [15:0] exp_seg [$];
  int n_mismatch = 0;
  int checked = 0;
  integer seed = 32;

  // The line has a pull-up: it is low only while some party drives it.
  assign line_lvl = rel & (line_oe_n | line_out);
  always #5 ref_clk = ~ref_clk;

  trig_frame_link #(.ADDR_W(5)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .angle_in(angle_in), .temp_in(temp_in), .warn_in(warn_in), .err_in(err_in),
    .line_in(line_lvl), .line_out(line_out), .line_oe_n(line_oe_n)
  );

  trig_master_model #(.HALF(HALF)) model_u (
    .ref_clk(ref_clk), .rstn(rstn), .trig_go(trig_go), .trig_halves(trig_halves),
    .line_lvl(line_lvl), .rel(rel), .seg_valid(seg_valid), .seg(seg)
  );

  task automatic give_verdict;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_rsp(input logic [33:0] seen);
    checked++;
    if (exp_rsp.size() == 0 || exp_rsp[0] !== seen)
    begin
      n_mismatch++;
      $display("BAD response exp %h seen %h", exp_rsp.size() ? exp_rsp[0] : 34'h0, seen);
    end
    if (exp_rsp.size() > 0)
      void'(exp_rsp.pop_front());
  endtask

  task automatic chk_seg(input logic [15:0] seen);
    checked++;
    if (exp_seg.size() == 0 || exp_seg[0] !== seen)
    begin
      n_mismatch++;
      $display("BAD segment exp %h seen %h", exp_seg.size() ? exp_seg[0] : 16'h0, seen);
    end
    if (exp_seg.size() > 0)
      void'(exp_seg.pop_front());
  endtask

  // Outputs are taken at the edge where the handshake or the segment is seen.
  always @(posedge ref_clk)
  begin
    if (bvalid && bready)
      chk_rsp({bresp, 32'h0});
    if (rvalid && rready)
      chk_rsp({rresp, rdata});
    if (seg_valid)
      chk_seg(seg);
  end

  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    exp_rsp.push_back({er, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // One idle edge keeps a following call from raising bready in the same step.
    @(posedge ref_clk);
    if (!done)
    begin
      n_mismatch++;
      give_verdict;
    end
  endtask

  task automatic axi_rd(input logic [4:0] a, input logic [33:0] e);
    int n;
    logic done;
    exp_rsp.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++)
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge ref_clk);
    if (!done)
    begin
      n_mismatch++;
      give_verdict;
    end
  endtask

  function automatic logic [3:0] mul16(input logic [3:0] v);
    logic [3:0] r;
    int i;
    r = v;
    for (i = 0; i < 4; i++)
      r = r[3] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction

  // Expected segments: trigger, sync, nibbles; the checksum is augmented by one zero nibble.
  task automatic exp_frame(input logic [7:0] th, input logic [7:0] ih, input logic [7:0] lh,
                           input logic [1:0] ad, input logic fold, input logic [3:0] cn);
    logic [3:0] nib [6];
    logic [3:0] c;
    int k;
    nib = '{{err_in, warn_in, ad}, angle_in[11:8], angle_in[7:4], angle_in[3:0],
            fold ? {cn[1:0], 2'b00} : cn, 4'h0};
    c = CRC_SEED;
    for (k = 0; k < 5; k++)
      c = nib[k] ^ mul16(c);
    nib[5] = mul16(c);
    exp_seg.push_back({th, ih});
    exp_seg.push_back({lh, 8'h70});
    for (k = 0; k < 6; k++)
      if (!(fold && k == 4))
        exp_seg.push_back({lh, 8'h18 + {3'h0, nib[k], 1'b0}});
  endtask

  task automatic new_inputs;
    logic [31:0] r;
    r = $random(seed);
    angle_in <= r[11:0];
    temp_in <= r[19:12];
    warn_in <= r[20];
    err_in <= r[21];
    @(posedge ref_clk);
  endtask

  task automatic trig(input logic [7:0] h);
    trig_halves <= h;
    trig_go <= 1'b1;
    @(posedge ref_clk);
    trig_go <= 1'b0;
  endtask

  task automatic wait_frame;
    int n;
    for (n = 0; n < 60000 && exp_seg.size() > 0; n++)
      @(posedge ref_clk);
    if (exp_seg.size() > 0)
    begin
      n_mismatch++;
      give_verdict;
    end
    repeat (30 * HALF) @(posedge ref_clk);
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (5) @(posedge ref_clk);
    axi_rd(CTRL_OFS, {RESP_OKAY, CTRL_RESET});
    axi_rd(STAT_OFS, {RESP_OKAY, 32'h0});
    axi_rd(5'h14, {RESP_SLVERR, 32'h0});
    axi_wr(5'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_wr(BASE_OFS, 32'hABCD_1234, RESP_OKAY);
    axi_rd(BASE_OFS, {RESP_OKAY, 32'h0000_1234});
    $display("test registers done");
    new_inputs;
    exp_frame(8'h15, 8'hB4, 8'h06, 2'b00, 1'b0, 4'h0);
    trig(8'h15);
    wait_frame;
    $display("test constant frame done");
    axi_wr(CTRL_OFS, 32'h0000_0029, RESP_OKAY);
    axi_rd(CTRL_OFS, {RESP_OKAY, 32'h0000_0029});
    trig(8'h15);
    repeat (80 * HALF) @(posedge ref_clk);
    $display("test foreign trigger done");
    new_inputs;
    exp_frame(8'h2A, 8'h42, 8'h0A, 2'b01, 1'b1, 4'h1);
    trig(8'h2A);
    wait_frame;
    $display("test variable folded frame done");
    give_verdict;
  end
endmodule // trig_frame_link_tb
`default_nettype wire
